// ===== tlipc_ctrl.sv
// Two-level interrupt priority controller with AXI4-Lite registers
// Functional notes
// (R01) Each source picks high or low level
// (R02) High routine blocks low; low preemptible
// (R03) Same level: fixed order, index 0 first
// (R04) Vector 03h step 8; serial 3Bh onward
// (R05) Sample and resolve once per machine cycle
// (R06) Withhold call if equal/higher in service
// (R07) Call only on instruction's last cycle
// (R08) No call on enable/priority write or return
// (R09) Denied requests are not remembered
// (R10) Return-from-interrupt clears active in-service marker
// (R11) Plain return leaves in-service marker set
// (R12) Global enable gates all source enables
// (R13) Caller-line flag is OR of detectors
// (R14) Vectoring clears edge and timer flags
// (R15) Priority bit one means high level
`timescale 1ns/1ps
module tlipc_ctrl
  import tlipc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [N_SRC-1:0] req_flags_i,
  input wire logic [7:0] caller_det_flags_i,
  input wire logic ext0_level_i,
  input wire logic ext1_level_i,
  input wire logic last_cycle_i,
  input wire logic prio_write_i,
  input wire logic return_from_irq_i,
  input wire logic plain_return_i,
  output logic long_call_op_o,
  output logic [7:0] vector_o,
  output logic [N_SRC-1:0] flag_clear_o,
  output logic mc_tick_o,
  output logic in_service_hi_o,
  output logic in_service_lo_o,
  output logic irq_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] vector_of(input logic [3:0] idx);
    logic [7:0] v;
    if (idx < 4'(N_BASE_SRC)) begin
      v = VEC_BASE_LO + 8'(idx) * VEC_STEP; // [R04]
    end else begin
      v = VEC_BASE_HI + 8'(idx - 4'(SERIAL_SRC)) * VEC_STEP; // [R04]
    end
    return v;
  endfunction : vector_of

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_SERVICE);
  endfunction : mapped

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic s);
    return s ? d[7:0] : old;
  endfunction : merge

  tlipc_state_t st;
  tlipc_state_t next_st;
  logic [N_SRC-1:0] en_vec;
  logic [N_SRC-1:0] prio_vec;
  logic [N_SRC-1:0] flags;
  logic [N_SRC-1:0] sampled;
  logic [N_SRC-1:0] hw_clearable;
  tlipc_pick_t pick_hi;
  tlipc_pick_t pick_lo;

  ////////////////////////////////////////////////////////////////////////////
  // Map per-source enable and priority bits from the two register pairs
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_map
      if (g < N_BASE_SRC) begin : g_base
        assign en_vec[g] = st.ie[g];
        assign prio_vec[g] = st.ip[g]; // [R01] [R15]
      end else if (g == SERIAL_SRC) begin : g_ser
        assign en_vec[g] = st.ie[SERIAL_BIT];
        assign prio_vec[g] = st.ip[SERIAL_BIT]; // [R01] [R15]
      end else begin : g_ext
        assign en_vec[g] = st.ext_irq_enable_reg[g-SERIAL_SRC-1];
        assign prio_vec[g] = st.ext_prio_reg[g-SERIAL_SRC-1]; // [R01] [R15]
      end
    end
  endgenerate

  always_comb begin
    flags = req_flags_i;
    flags[CALLER_SRC] = |caller_det_flags_i; // [R13]
    // Level-mode externals must stay asserted by their source
    hw_clearable = '1; // [R14]
    hw_clearable[0] = ~ext0_level_i; // [R14]
    hw_clearable[2] = ~ext1_level_i; // [R14]
    hw_clearable[CALLER_SRC] = 1'b0; // [R13]
    hw_clearable[WATCHDOG_SRC] = 1'b0;
    // Live flags only: nothing is latched between polls
    sampled = flags & en_vec & {N_SRC{st.ie[GLOBAL_EN_BIT]}}; // [R09] [R12]
  end

  tlipc_pick u_pick_hi (
    .req_i(sampled & prio_vec), // [R03]
    .pick_o(pick_hi)
  );

  tlipc_pick u_pick_lo (
    .req_i(sampled & ~prio_vec), // [R03]
    .pick_o(pick_lo)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic tick;
    logic legal;
    logic take_hi;
    logic take_lo;
    logic [N_EVT-1:0] evt;
    logic [N_EVT-1:0] clr;
    logic do_wr;
    logic [7:0] ra;
    tick = 1'b0;
    legal = 1'b0;
    take_hi = 1'b0;
    take_lo = 1'b0;
    evt = '0;
    clr = '0;
    do_wr = 1'b0;
    ra = s_axi_araddr;
    next_st = st;
    next_st.long_call_op = 1'b0;
    next_st.fclr = '0;

    // Machine-cycle divider
    tick = (st.mc_cnt == MC_LAST);
    next_st.mc_cnt = st.mc_cnt + 2'h1;
    // Registered so the tick output is a flop and stays low in reset
    next_st.tick = tick;

    // Poll on the machine-cycle tick
    legal = tick && last_cycle_i; // [R05] [R07]
    legal = legal && !prio_write_i && !return_from_irq_i; // [R08]
    take_hi = legal && pick_hi.valid && !st.in_hi; // [R02] [R06]
    take_lo = legal && !pick_hi.valid && pick_lo.valid
              && !st.in_hi && !st.in_lo; // [R02] [R06]
    if (take_hi) begin
      next_st.long_call_op = 1'b1;
      next_st.vec = vector_of(pick_hi.idx); // [R04]
      next_st.in_hi = 1'b1;
      next_st.fclr[pick_hi.idx] = hw_clearable[pick_hi.idx]; // [R14]
      evt[EVT_CALL] = 1'b1;
    end else if (take_lo) begin
      next_st.long_call_op = 1'b1;
      next_st.vec = vector_of(pick_lo.idx); // [R04]
      next_st.in_lo = 1'b1;
      next_st.fclr[pick_lo.idx] = hw_clearable[pick_lo.idx]; // [R14]
      evt[EVT_CALL] = 1'b1;
    end else if (tick && (pick_hi.valid || pick_lo.valid)) begin
      evt[EVT_WITHHELD] = 1'b1;
    end

    // Return from interrupt retires the most recent level
    if (tick && return_from_irq_i) begin
      if (st.in_hi) begin
        next_st.in_hi = 1'b0; // [R10]
      end else begin
        next_st.in_lo = 1'b0; // [R10]
      end
      evt[EVT_RETURN] = 1'b1;
    end
    // A plain return is seen but never touches the markers
    if (plain_return_i) begin
      next_st.in_hi = next_st.in_hi; // [R11]
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data accepted in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    // Both halves must be in; a standing response holds off the next write
    do_wr = st.aw_got && st.w_got && !st.bvalid;
    if (do_wr) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (st.awaddr)
        OFF_IRQ_EN: next_st.ie = merge(st.ie, st.wdata, st.wstrb[0]);
        OFF_EXT_EN: next_st.ext_irq_enable_reg = merge(st.ext_irq_enable_reg, st.wdata, st.wstrb[0]);
        OFF_PRIO_LOW: next_st.ip = merge(st.ip, st.wdata, st.wstrb[0]);
        OFF_EXT_PRIO: next_st.ext_prio_reg = merge(st.ext_prio_reg, st.wdata, st.wstrb[0]);
        OFF_EVT_CLEAR: clr = st.wstrb[0] ? st.wdata[N_EVT-1:0] : '0;
        OFF_EVT_ENABLE: begin
          if (st.wstrb[0]) begin
            next_st.msk = st.wdata[N_EVT-1:0];
          end
        end
        default: ;
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    // AXI4-Lite read path
    // Data latched with the address, so it stands until rready
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      next_st.rdata = '0;
      case (ra)
        OFF_IRQ_EN: next_st.rdata[7:0] = st.ie;
        OFF_EXT_EN: next_st.rdata[7:0] = st.ext_irq_enable_reg;
        OFF_PRIO_LOW: next_st.rdata[7:0] = st.ip;
        OFF_EXT_PRIO: next_st.rdata[7:0] = st.ext_prio_reg;
        OFF_EVT_STATUS: next_st.rdata[N_EVT-1:0] = st.sts;
        OFF_EVT_ENABLE: next_st.rdata[N_EVT-1:0] = st.msk;
        OFF_SERVICE: next_st.rdata[9:0] = {st.in_hi, st.in_lo, st.vec};
        default: ;
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;

    // Sticky events; a set in the clearing cycle survives
    next_st.sts = (st.sts & ~clr) | evt;
    next_st.irq = |(next_st.sts & next_st.msk);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign long_call_op_o = st.long_call_op;
  assign vector_o = st.vec;
  assign flag_clear_o = st.fclr;
  assign mc_tick_o = st.tick;
  assign in_service_hi_o = st.in_hi;
  assign in_service_lo_o = st.in_lo;
  assign irq_o = st.irq;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;

endmodule : tlipc_ctrl

// ===== tlipc_pick.sv
// Package for the interrupt priority controller and its fixed-order picker
package tlipc_pkg;
  localparam int N_SRC = 11;
  localparam int CLKS_PER_MC = 4;
  localparam logic [1:0] MC_LAST = 2'h3;
  // Register byte offsets
  localparam logic [7:0] OFF_IRQ_EN = 8'h00;
  localparam logic [7:0] OFF_EXT_EN = 8'h04;
  localparam logic [7:0] OFF_PRIO_LOW = 8'h08;
  localparam logic [7:0] OFF_EXT_PRIO = 8'h0c;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h10;
  localparam logic [7:0] OFF_EVT_CLEAR = 8'h14;
  localparam logic [7:0] OFF_EVT_ENABLE = 8'h18;
  localparam logic [7:0] OFF_SERVICE = 8'h1c;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int SERIAL_BIT = 6;
  localparam int N_BASE_SRC = 4;
  localparam int SERIAL_SRC = 4;
  localparam int CALLER_SRC = 7;
  localparam int WATCHDOG_SRC = 10;
  // Vectors
  localparam logic [7:0] VEC_BASE_LO = 8'h03;
  localparam logic [7:0] VEC_BASE_HI = 8'h3b;
  localparam logic [7:0] VEC_STEP = 8'h08;
  // Event status bits
  localparam int N_EVT = 3;
  localparam int EVT_CALL = 0;
  localparam int EVT_RETURN = 1;
  localparam int EVT_WITHHELD = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic valid;
    logic [3:0] idx;
  } tlipc_pick_t;

  typedef struct packed {
    logic [1:0] mc_cnt;
    logic tick;
    logic [7:0] ie;
    logic [7:0] ext_irq_enable_reg;
    logic [7:0] ip;
    logic [7:0] ext_prio_reg;
    logic [N_EVT-1:0] sts;
    logic [N_EVT-1:0] msk;
    logic in_hi;
    logic in_lo;
    logic long_call_op;
    logic [7:0] vec;
    logic [N_SRC-1:0] fclr;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tlipc_state_t;
endpackage : tlipc_pkg

`timescale 1ns/1ps
module tlipc_pick
  import tlipc_pkg::*;
(
  input wire logic [N_SRC-1:0] req_i,
  output tlipc_pick_t pick_o
);
  always_comb begin
    pick_o = '0;
    // Walk from the lowest rank up so the lowest index wins
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        pick_o.valid = 1'b1;
        pick_o.idx = 4'(i);
      end
    end
  end
endmodule : tlipc_pick

// ===== tlipc_ctrl_properties.sv
// Checker for the processor-facing side of the priority controller
`timescale 1ns/1ps
module tlipc_ctrl_properties
  import tlipc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [N_SRC-1:0] req_flags_i,
  input wire logic [7:0] caller_det_flags_i,
  input wire logic last_cycle_i,
  input wire logic prio_write_i,
  input wire logic return_from_irq_i,
  input logic long_call_op_o,
  input logic [7:0] vector_o,
  input logic [N_SRC-1:0] flag_clear_o,
  input logic mc_tick_o,
  input logic in_service_hi_o,
  input logic in_service_lo_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  call_pulse_a: assert property (long_call_op_o |=> !long_call_op_o)
    else $error("call pulse longer than one cycle");
  poll_gate_a: assert property (long_call_op_o |->
    $past(last_cycle_i && !prio_write_i && !return_from_irq_i))
    else $error("call issued outside a legal poll");
  call_tick_a: assert property (long_call_op_o |-> mc_tick_o)
    else $error("call not aligned to machine cycle");
  tick_gap_a: assert property (
    mc_tick_o |=> !mc_tick_o [*3] ##1 mc_tick_o)
    else $error("machine cycle not four clocks");
  hi_block_a: assert property (
    long_call_op_o |-> !$past(in_service_hi_o))
    else $error("call while high routine active");
  nest_level_a: assert property (
    long_call_op_o && $past(in_service_lo_o) |-> in_service_hi_o)
    else $error("low routine not preempted");
  req_seen_a: assert property (long_call_op_o |-> $past(
    (req_flags_i & 11'h77f) != 11'h000 || caller_det_flags_i != 8'h00))
    else $error("call without request");
  vec_form_a: assert property (
    long_call_op_o |-> vector_o[2:0] == 3'h3 && vector_o <= 8'h6b)
    else $error("vector off grid");
  vec_hold_a: assert property (
    !long_call_op_o |-> $stable(vector_o))
    else $error("vector moved without call");
  clr_call_a: assert property (
    flag_clear_o != 11'h000 |->
    long_call_op_o && !flag_clear_o[7] && !flag_clear_o[10])
    else $error("bad flag clear");
endmodule : tlipc_ctrl_properties

bind tlipc_ctrl tlipc_ctrl_properties chk_u (.sys_clk_i, .nrst_i,
  .req_flags_i, .caller_det_flags_i, .last_cycle_i, .prio_write_i,
  .return_from_irq_i, .long_call_op_o, .vector_o, .flag_clear_o, .mc_tick_o,
  .in_service_hi_o, .in_service_lo_o);

// ===== tlipc_cpu_model.sv
// Processor model driving instruction-state lines
`timescale 1ns/1ps
module tlipc_cpu_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic long_call_i,
  input wire logic tick_i,
  input wire logic [1:0] op_i,
  output logic last_cycle_o,
  output logic return_o,
  output logic plain_o,
  output logic [3:0] depth_o
);
  // Op 0 mid-instruction, 1 last cycle, 2 irq return, 3 plain return
  assign last_cycle_o = op_i != 2'h0;
  assign return_o = op_i == 2'h2;
  assign plain_o = op_i == 2'h3;
  // Stack depth only; return addresses play no part at these ports
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) depth_o <= 4'h0;
    else if (long_call_i) depth_o <= depth_o + 4'h1;
    else if ((return_o || plain_o) && tick_i && depth_o != 4'h0)
      depth_o <= depth_o - 4'h1;
  end
endmodule : tlipc_cpu_model

// ===== tb_tlipc_ctrl.sv
// Self-checking bench for the priority controller
`timescale 1ns/1ps
module tb_tlipc_ctrl;
  import tlipc_pkg::*;
  logic sys_clk_i, nrst_i, ext0_level_i, prio_write_i, awvalid, awready;
  logic ext1_level_i;
  logic wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic last_cycle, ret_irq, plain, call, mc_tick, in_hi, in_lo, irq;
  logic [N_SRC-1:0] req_flags_i, fclr, fc_seen;
  logic [7:0] caller_det_flags_i, awaddr, araddr, vector;
  logic [1:0] op, bresp, rresp;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] depth;
  int fail_count, check_count;
  tlipc_ctrl dut_u (.sys_clk_i, .nrst_i, .req_flags_i, .caller_det_flags_i,
    .ext0_level_i, .ext1_level_i, .last_cycle_i(last_cycle),
    .prio_write_i, .return_from_irq_i(ret_irq), .plain_return_i(plain),
    .long_call_op_o(call), .vector_o(vector), .flag_clear_o(fclr),
    .mc_tick_o(mc_tick), .in_service_hi_o(in_hi), .in_service_lo_o(in_lo),
    .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tlipc_cpu_model cpu_u (.sys_clk_i, .nrst_i, .long_call_i(call),
    .tick_i(mc_tick), .op_i(op), .last_cycle_o(last_cycle),
    .return_o(ret_irq), .plain_o(plain), .depth_o(depth));
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, (a < 8'h20) ? RESP_OKAY : RESP_SLVERR);
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
    rready <= 1'b0;
    chk(rresp, (a < 8'h20) ? RESP_OKAY : RESP_SLVERR);
  endtask : rd
  // Hold the op across exactly one poll; skip a tick left from before
  task do_op(input logic [1:0] o);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    op <= o;
    @(posedge sys_clk_i);
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (!mc_tick && n < 12);
    op <= 2'h1;
  endtask : do_op
  task expect_call(input logic eg, input logic [7:0] ev);
    logic g;
    g = 1'b0;
    repeat (12) begin
      @(posedge sys_clk_i);
      if (call === 1'b1) begin
        g = 1'b1;
        fc_seen = fclr;
      end
    end
    chk(g, eg);
    if (eg) chk(vector, ev);
  endtask : expect_call
  function automatic logic [7:0] vec_of(input int i);
    return (i < 4) ? 8'(8'h03 + 8 * i) : 8'(8'h3b + 8 * (i - 4));
  endfunction : vec_of
  task report_and_stop;
    $display("Mismatches %0d, checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////
  task s_regs;
    rd(OFF_IRQ_EN);
    chk(rdv, 32'h0);
    wr(OFF_PRIO_LOW, 32'h55);
    rd(OFF_PRIO_LOW);
    chk(rdv, 32'h55);
    wr(8'h40, 32'h1);
    rd(8'h40);
  endtask : s_regs
  task s_order;
    wr(OFF_IRQ_EN, 32'h4f);
    wr(OFF_PRIO_LOW, 32'h0);
    req_flags_i <= 11'h002;
    expect_call(1'b0, 8'h00);
    req_flags_i <= 11'h000;
    wr(OFF_IRQ_EN, 32'hcf);
    wr(OFF_EXT_EN, 32'h3f);
    for (int i = 0; i < N_SRC; i++) begin
      req_flags_i <= 11'h7ff << i;
      caller_det_flags_i <= (i <= 7) ? 8'h10 : 8'h00;
      expect_call(1'b1, vec_of(i));
      chk(fc_seen, (i == 7 || i == 10) ? 0 : 1 << i);
      req_flags_i <= 11'h000;
      caller_det_flags_i <= 8'h00;
      do_op(2'h2);
      chk(in_lo, 1'b0);
    end
  endtask : s_order
  task s_nest;
    req_flags_i <= 11'h100;
    expect_call(1'b1, 8'h5b);
    req_flags_i <= 11'h000;
    do_op(2'h3);
    chk(in_lo, 1'b1);
    wr(OFF_PRIO_LOW, 32'h02);
    req_flags_i <= 11'h002;
    expect_call(1'b1, 8'h0b);
    req_flags_i <= 11'h001;
    expect_call(1'b0, 8'h00);
    do_op(2'h2);
    chk({in_hi, in_lo}, 2'b01);
    expect_call(1'b0, 8'h00);
    do_op(2'h2);
    expect_call(1'b1, 8'h03);
    req_flags_i <= 11'h000;
    do_op(2'h2);
  endtask : s_nest
  task s_deny;
    req_flags_i <= 11'h001;
    op <= 2'h0;
    expect_call(1'b0, 8'h00);
    req_flags_i <= 11'h000;
    op <= 2'h1;
    expect_call(1'b0, 8'h00);
    prio_write_i <= 1'b1;
    req_flags_i <= 11'h001;
    expect_call(1'b0, 8'h00);
    prio_write_i <= 1'b0;
    op <= 2'h2;
    expect_call(1'b0, 8'h00);
    op <= 2'h1;
    ext1_level_i <= 1'b1;
    req_flags_i <= 11'h004;
    expect_call(1'b1, 8'h13);
    chk(fc_seen, 11'h000);
    req_flags_i <= 11'h000;
    ext1_level_i <= 1'b0;
    do_op(2'h2);
    ext0_level_i <= 1'b1;
    req_flags_i <= 11'h001;
    expect_call(1'b1, 8'h03);
    chk(fc_seen, 11'h000);
    req_flags_i <= 11'h000;
    ext0_level_i <= 1'b0;
    do_op(2'h2);
  endtask : s_deny
  task s_irq;
    wr(OFF_EVT_ENABLE, 32'h0);
    chk(depth, 4'h0);
    repeat (2) @(posedge sys_clk_i);
    chk(irq, 1'b0);
    wr(OFF_EVT_ENABLE, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    chk(irq, 1'b1);
    rd(OFF_EVT_STATUS);
    chk(rdv[2:0], 3'h7);
    wr(OFF_EVT_CLEAR, 32'h7);
    repeat (2) @(posedge sys_clk_i);
    chk(irq, 1'b0);
    rd(OFF_SERVICE);
    chk(rdv, 32'h03);
  endtask : s_irq
  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {nrst_i, ext0_level_i, prio_write_i, awvalid, wvalid, bready} = '0;
    ext1_level_i = 1'b0;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    req_flags_i = '0;
    caller_det_flags_i = '0;
    op = 2'h1;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    s_regs();
    s_order();
    s_nest();
    s_deny();
    s_irq();
    report_and_stop();
  end
endmodule : tb_tlipc_ctrl
